// File: spseq_pkg.sv
// Purpose: shared constants and types of the stop-mode power sequencer
// Assumes: 32-bit APB register access, single bus clock
// Notes: register offsets are byte addresses
package spseq_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_ACK = 8'h08;

  // control register fields
  localparam int unsigned CTRL_W = 7;
  localparam int unsigned CB_STOP_EN = 0;
  localparam int unsigned CB_DEEP_SEL = 1;
  localparam int unsigned CB_LOWV_EN = 2;
  localparam int unsigned CB_LOWV_STOP = 3;
  localparam int unsigned CB_OSC_STOP = 4;
  localparam int unsigned CB_CONV_ASYNC = 5;
  localparam int unsigned CB_DBG_EN = 6;
  localparam logic [6:0] CTRL_RST = 7'h00;

  // acknowledge register field
  localparam int unsigned AB_PIN_ACK = 0;

  // ----------------------------------------
  // wake sources
  // ----------------------------------------
  localparam int unsigned NUM_WAKE = 7;
  localparam int unsigned WK_PERIODIC = 0;
  localparam int unsigned WK_LOW_VOLT = 1;
  localparam int unsigned WK_CONV = 2;
  localparam int unsigned WK_EXT_IRQ = 3;
  localparam int unsigned WK_KEYPAD = 4;
  localparam int unsigned WK_SERIAL = 5;
  localparam int unsigned WK_RST_PIN = 6;
  localparam logic [6:0] WAKE_SHALLOW = 7'h7f;
  localparam logic [6:0] WAKE_DEEP = 7'h49;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam logic [3:0] RST_PULSE = 4'h8;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {MD_RUN, MD_SHALLOW, MD_DEEP, MD_WAKE, MD_BKG} spseq_mode_t;

  typedef enum logic [2:0] {
    DBG_BGND, DBG_MEM_STAT, DBG_MEM, DBG_BDC_REG, DBG_CPU_REG, DBG_TRACE, DBG_GO
  } spseq_dbg_kind_t;

  typedef struct packed {
    logic valid;
    spseq_dbg_kind_t kind;
  } spseq_dbg_req_t;

  typedef struct packed {
    logic ack;
    logic err_stopped;
  } spseq_dbg_rsp_t;

  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic dbg_clk_en;
    logic clkgen_standby;
    logic clkgen_off;
    logic osc_run;
    logic reg_standby;
    logic conv_standby;
    logic conv_run_stop;
    logic keypad_wake_en;
    logic keypad_off;
    logic pin_latch;
  } spseq_pwr_t;

  typedef struct packed {
    spseq_mode_t mode;
    logic [6:0] ctrl;
    logic wake_flag;
    logic pin_latch;
    logic [3:0] cnt;
    logic [6:0] wk_s1;
    logic [6:0] wk_s2;
    spseq_pwr_t pwr;
    logic rst_req;
    logic ill_rst;
    spseq_dbg_rsp_t dbg_rsp;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } spseq_state_t;

endpackage

// File: spseq_top.sv
// Purpose: stop-mode power sequencer, decides stop depth and gates power
// Assumes: CPU stop pulse and debug commands on CLK, wake sources async
// Notes: registers over APB, zero wait states
//
// Behaviour
// RULE1 - background entry from run needs debug enable
// RULE2 - debug enable keeps debug clocks in stop
// RULE3 - debug enable keeps regulator fully active
// RULE4 - debug enable turns deep into shallow stop
// RULE5 - memory-status commands in stop return error; code returns it in shallow stop only, no answer in deep stop
// RULE6 - background command wakes stop into debug
// RULE7 - all debug commands accepted in background
// RULE8 - low-volt detect in stop keeps regulator
// RULE9 - low-volt detect in stop forces shallow
// RULE10 - peripheral clocks stop in every stop
// RULE11 - shallow stop keeps pins and registers
// RULE12 - deep stop latches pins before entry
// RULE13 - deep wake resets registers, pins stay latched
// RULE14 - shallow: clock generator standby, oscillator optional
// RULE15 - deep: clock generator off, reset on wake
// RULE16 - timers halt, reset after deep stop
// RULE17 - converter standby unless async clock enabled; code puts it in standby in deep stop even with async clock enabled
// RULE18 - keypad wakes shallow, disabled in deep
// RULE19 - serial units halt, reset after deep
// RULE20 - regulator standby unless low-volt or debug
// RULE21 - stop without enable forces illegal reset
// RULE22 - select bit picks deep or shallow
// RULE23 - wake flag and latches held until ack
// RULE24 - listed interrupts or reset pin wake shallow
// RULE25 - overrides decided in stop instruction cycle
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module spseq_top
  import spseq_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // cpu
  input wire logic STOP_EXEC,
  output logic ILLEGAL_RESET,
  // wake sources
  input wire logic [NUM_WAKE-1:0] WAKE_SRC,
  // debug logic
  input wire spseq_dbg_req_t DBG_REQ,
  output spseq_dbg_rsp_t DBG_RSP,
  // power, clock and reset control
  output spseq_pwr_t PWR,
  output logic SYS_RESET_REQ,
  output logic [2:0] MODE
);

  spseq_state_t q;
  spseq_state_t d;
  logic dbg_en;
  logic lv_stop;
  logic go_deep;
  logic setup;
  logic access;
  logic stopped;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    d = q;
    d.ill_rst = 1'b0;
    d.dbg_rsp = '0;
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    d.prdata = '0;
    d.wk_s1 = WAKE_SRC;
    d.wk_s2 = q.wk_s1;
    dbg_en = q.ctrl[CB_DBG_EN];
    lv_stop = q.ctrl[CB_LOWV_EN] & q.ctrl[CB_LOWV_STOP];
    // overrides resolved in the stop cycle itself
    go_deep = q.ctrl[CB_DEEP_SEL] & ~dbg_en & ~lv_stop; // see RULE22 see RULE25
    setup = PSEL & ~PENABLE;
    access = PSEL & PENABLE & q.pready;

    // apb: answer prepared in setup, shown in access
    if (setup)
    begin
      d.pready = 1'b1;
      case (PADDR)
        OFS_CTRL: d.prdata = {25'h0, q.ctrl};
        OFS_STAT: d.prdata = {26'h0, q.mode == MD_BKG, q.pin_latch, q.wake_flag, q.mode};
        OFS_ACK: d.prdata = '0;
        default: d.pslverr = 1'b1;
      endcase
    end
    if (access && PWRITE)
    begin
      if (PADDR == OFS_CTRL)
      begin
        d.ctrl = PWDATA[CTRL_W-1:0];
      end
      if (PADDR == OFS_ACK && PWDATA[AB_PIN_ACK])
      begin
        d.wake_flag = 1'b0; // see RULE23
        d.pin_latch = 1'b0; // see RULE13
      end
    end

    // mode sequencing; a set below wins over the clear above
    case (q.mode)
      MD_RUN:
      begin
        if (STOP_EXEC)
        begin
          if (!q.ctrl[CB_STOP_EN])
          begin
            d.ill_rst = 1'b1; // see RULE21
          end
          else if (go_deep)
          begin
            d.mode = MD_DEEP;
            d.pin_latch = 1'b1; // see RULE12
          end
          else
          begin
            d.mode = MD_SHALLOW; // see RULE4 see RULE9 see RULE11
          end
        end
        else if (DBG_REQ.valid)
        begin
          case (DBG_REQ.kind)
            DBG_BGND:
            begin
              if (dbg_en)
              begin
                d.mode = MD_BKG; // see RULE1
                d.dbg_rsp.ack = 1'b1;
              end
              else
              begin
                d.dbg_rsp.err_stopped = 1'b0;
              end
            end
            DBG_CPU_REG, DBG_TRACE, DBG_GO: d.dbg_rsp.ack = 1'b0;
            default: d.dbg_rsp.ack = 1'b1;
          endcase
        end
      end
      MD_SHALLOW:
      begin
        // still stopped in this cycle, even if a wake arrives with it
        if (DBG_REQ.valid && DBG_REQ.kind == DBG_MEM_STAT)
        begin
          d.dbg_rsp.err_stopped = 1'b1; // see RULE5
        end
        if (DBG_REQ.valid && DBG_REQ.kind == DBG_BGND && dbg_en)
        begin
          d.mode = MD_BKG; // see RULE6
          d.dbg_rsp.ack = 1'b1;
        end
        else if (|(q.wk_s2 & WAKE_SHALLOW))
        begin
          d.mode = MD_RUN; // see RULE24 see RULE18
        end
      end
      MD_DEEP:
      begin
        if (|(q.wk_s2 & WAKE_DEEP))
        begin
          d.mode = MD_WAKE;
          d.cnt = RST_PULSE - 4'h1;
        end
      end
      MD_WAKE:
      begin
        if (q.cnt == 4'h0)
        begin
          d.mode = MD_RUN;
          d.wake_flag = 1'b1; // see RULE23
          d.pin_latch = 1'b1;
          d.ctrl = CTRL_RST; // see RULE13
        end
        else
        begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      MD_BKG:
      begin
        if (DBG_REQ.valid)
        begin
          d.dbg_rsp.ack = 1'b1; // see RULE7
          if (DBG_REQ.kind == DBG_GO)
          begin
            d.mode = MD_RUN;
          end
        end
      end
      default: d.mode = MD_RUN;
    endcase

    // power and clock controls follow the next mode
    stopped = (d.mode == MD_SHALLOW) || (d.mode == MD_DEEP);
    d.pwr.cpu_clk_en = (d.mode == MD_RUN) || (d.mode == MD_BKG);
    d.pwr.periph_clk_en = ~stopped && (d.mode != MD_WAKE); // see RULE10 see RULE16 see RULE19
    d.pwr.dbg_clk_en = ~stopped || (d.mode == MD_SHALLOW && dbg_en); // see RULE2
    d.pwr.reg_standby = stopped && ~dbg_en && ~lv_stop; // see RULE3 see RULE8 see RULE20
    d.pwr.clkgen_standby = (d.mode == MD_SHALLOW) && ~dbg_en; // see RULE14
    d.pwr.clkgen_off = (d.mode == MD_DEEP); // see RULE15
    d.pwr.osc_run = ~stopped ||
      ((d.mode == MD_SHALLOW) && (q.ctrl[CB_OSC_STOP] || dbg_en)); // see RULE14
    d.pwr.conv_standby = stopped &&
      ~((d.mode == MD_SHALLOW) && q.ctrl[CB_CONV_ASYNC]); // see RULE17
    d.pwr.conv_run_stop = (d.mode == MD_SHALLOW) && q.ctrl[CB_CONV_ASYNC];
    d.pwr.keypad_wake_en = (d.mode == MD_SHALLOW); // see RULE18
    d.pwr.keypad_off = (d.mode == MD_DEEP);
    d.pwr.pin_latch = d.pin_latch; // see RULE12
    // power-on style reset of registers and units after deep stop
    d.rst_req = (d.mode == MD_WAKE); // see RULE13 see RULE15 see RULE16 see RULE19
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign PRDATA = q.prdata;
  assign PREADY = q.pready;
  assign PSLVERR = q.pslverr;
  assign ILLEGAL_RESET = q.ill_rst;
  assign DBG_RSP = q.dbg_rsp;
  assign PWR = q.pwr;
  assign SYS_RESET_REQ = q.rst_req;
  assign MODE = q.mode;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  ill_stop_reset_a: assert property ( // see RULE21
    (q.mode == MD_RUN && STOP_EXEC && !q.ctrl[CB_STOP_EN])
      |=> (ILLEGAL_RESET && MODE == MD_RUN))
    else $error("stop without enable did not force reset");

  dbg_forces_shallow_a: assert property ( // see RULE4
    (q.mode == MD_RUN && STOP_EXEC && q.ctrl[CB_STOP_EN] && q.ctrl[CB_DBG_EN])
      |=> (MODE == MD_SHALLOW && !PWR.clkgen_off))
    else $error("debug enable did not force shallow stop");

  lv_forces_shallow_a: assert property ( // see RULE9
    (q.mode == MD_RUN && STOP_EXEC && q.ctrl[CB_STOP_EN]
      && q.ctrl[CB_LOWV_EN] && q.ctrl[CB_LOWV_STOP]) |=> (MODE == MD_SHALLOW))
    else $error("low-volt detect did not force shallow stop");

  deep_entry_latch_a: assert property ( // see RULE12
    (q.mode == MD_RUN && STOP_EXEC && q.ctrl[CB_STOP_EN] && go_deep)
      |=> (MODE == MD_DEEP && PWR.pin_latch && PWR.clkgen_off && !PWR.osc_run))
    else $error("deep stop entered without pin latch");

  periph_clk_off_a: assert property ( // see RULE10
    (MODE == MD_SHALLOW || MODE == MD_DEEP) |-> (!PWR.periph_clk_en && !PWR.cpu_clk_en))
    else $error("peripheral clock running in stop");

  regulator_kept_a: assert property ( // see RULE3
    (MODE == MD_SHALLOW && q.ctrl[CB_DBG_EN])
      |-> (!PWR.reg_standby && PWR.dbg_clk_en && !PWR.clkgen_standby))
    else $error("debug enabled stop lost regulator or clocks");

  mem_stat_err_a: assert property ( // see RULE5
    (q.mode == MD_SHALLOW && DBG_REQ.valid && DBG_REQ.kind == DBG_MEM_STAT)
      |=> (DBG_RSP.err_stopped && !DBG_RSP.ack))
    else $error("memory status command in stop gave no error");

  bgnd_wake_a: assert property ( // see RULE6
    (q.mode == MD_SHALLOW && DBG_REQ.valid && DBG_REQ.kind == DBG_BGND && q.ctrl[CB_DBG_EN])
      |=> (MODE == MD_BKG && DBG_RSP.ack))
    else $error("background command did not wake into debug");

  wake_reset_a: assert property ( // see RULE13
    $rose(SYS_RESET_REQ) |-> SYS_RESET_REQ[*8] ##1
      (!SYS_RESET_REQ && MODE == MD_RUN && q.wake_flag && PWR.pin_latch))
    else $error("deep wake reset pulse or flag wrong");

  flag_held_a: assert property ( // see RULE23
    (q.wake_flag && !(PSEL && PENABLE && PWRITE && PADDR == OFS_ACK))
      |=> q.wake_flag)
    else $error("wake flag cleared without acknowledge");

  bkg_needs_en_a: assert property ( // see RULE1
    (q.mode == MD_RUN && !STOP_EXEC && DBG_REQ.valid
      && DBG_REQ.kind == DBG_BGND && !dbg_en) |=> (MODE == MD_RUN && !DBG_RSP.ack))
    else $error("background entered without debug enable");

  bkg_cmd_ack_a: assert property ( // see RULE7
    (q.mode == MD_BKG && DBG_REQ.valid) |=> DBG_RSP.ack)
    else $error("background command not accepted");

  shallow_keeps_a: assert property ( // see RULE11
    (q.mode == MD_RUN && STOP_EXEC && q.ctrl[CB_STOP_EN] && !go_deep)
      |=> (!SYS_RESET_REQ && !PWR.clkgen_off && (!PWR.pin_latch || $past(q.pin_latch))))
    else $error("shallow stop disturbed pins or registers");

  shallow_clkgen_a: assert property ( // see RULE14
    (MODE == MD_SHALLOW && !$past(dbg_en))
      |-> (PWR.clkgen_standby && PWR.osc_run == $past(q.ctrl[CB_OSC_STOP])))
    else $error("clock generator wrong in shallow stop");

  deep_clkgen_a: assert property ( // see RULE15
    (MODE == MD_DEEP) |-> (PWR.clkgen_off && !PWR.clkgen_standby && !PWR.osc_run))
    else $error("clock generator still running in deep stop");

  conv_deep_a: assert property ( // see RULE17
    (MODE == MD_DEEP) |-> (PWR.conv_standby && !PWR.conv_run_stop))
    else $error("converter active in deep stop");

  keypad_deep_a: assert property ( // see RULE18
    (MODE == MD_DEEP) |-> (PWR.keypad_off && !PWR.keypad_wake_en))
    else $error("keypad unit active in deep stop");

  reg_standby_a: assert property ( // see RULE20
    ((MODE == MD_SHALLOW || MODE == MD_DEEP) && !$past(dbg_en) && !$past(lv_stop))
      |-> PWR.reg_standby)
    else $error("regulator not in standby during stop");

endmodule

`default_nettype wire

// File: spseq_dbg_host.sv
// Purpose: debug host model issuing background commands
// Assumes: commands launched just after a rising edge
// Notes: idle kind lines carry the inverted last value
`timescale 1ns/1ps
`default_nettype none
module spseq_dbg_host
  import spseq_pkg::*;
(
  // clock
  input wire logic clk,
  // command out
  output var spseq_dbg_req_t req
);
  initial req = '{1'b0, DBG_BGND};
  // one-cycle command, also legal while stopped
  task automatic send(input spseq_dbg_kind_t k);
    @(posedge clk);
    req <= '{1'b1, k};
    @(posedge clk);
    req <= '{1'b0, spseq_dbg_kind_t'(~k)};
  endtask
endmodule
`default_nettype wire

// File: tb_spseq_top.sv
// Purpose: self-checking bench for the stop-mode power sequencer
// Assumes: zero-wait APB, registered outputs
// Notes: each scenario is a task of its own
`timescale 1ns/1ps
`default_nettype none
module tb_spseq_top;
  import spseq_pkg::*;
  logic CLK, RESET_N, PSEL, PENABLE, PWRITE, STOP_EXEC;
  logic ILLEGAL_RESET, PREADY, PSLVERR, SYS_RESET_REQ, err;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [6:0] WAKE_SRC;
  logic [2:0] MODE;
  spseq_dbg_req_t DBG_REQ;
  spseq_dbg_rsp_t DBG_RSP;
  spseq_pwr_t PWR;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;

  spseq_top spseq_top_inst (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .STOP_EXEC(STOP_EXEC), .ILLEGAL_RESET(ILLEGAL_RESET),
    .WAKE_SRC(WAKE_SRC), .DBG_REQ(DBG_REQ), .DBG_RSP(DBG_RSP), .PWR(PWR),
    .SYS_RESET_REQ(SYS_RESET_REQ), .MODE(MODE));
  spseq_dbg_host spseq_dbg_host_inst (.clk(CLK), .req(DBG_REQ));

  initial
  begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end

  // hang guard
  always @(posedge CLK)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_of_test();
    if (miscompares == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chkw(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic chkb(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s exp %b got %b", n, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1)
      @(posedge CLK);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic stop();
    @(posedge CLK);
    STOP_EXEC <= 1'b1;
    @(posedge CLK);
    STOP_EXEC <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic dbg(input spseq_dbg_kind_t k);
    spseq_dbg_host_inst.send(k);
    @(posedge CLK);
  endtask

  task automatic wait_mode(input logic [2:0] e);
    int i;
    for (i = 0; i < 20 && MODE !== e; i++)
      @(posedge CLK);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_run();
    // run values appear only after the first edge out of reset
    @(posedge CLK);
    @(posedge CLK);
    chkw("mode", 32'h0, 32'(MODE));
    chkb("osc", 1'b1, PWR.osc_run);
    chkb("cpuclk", 1'b1, PWR.cpu_clk_en);
    apb(1'b0, 8'h0c, 32'h0);
    chkb("pslverr", 1'b1, err);
    stop();
    chkb("illegal", 1'b1, ILLEGAL_RESET);
    chkw("mode", 32'h0, 32'(MODE));
    dbg(DBG_BGND);
    chkb("ack", 1'b0, DBG_RSP.ack);
  endtask

  task automatic t_deep();
    apb(1'b1, OFS_CTRL, 32'h13);
    stop();
    chkw("mode", 32'h2, 32'(MODE));
    chkb("latch", 1'b1, PWR.pin_latch);
    chkb("cg_off", 1'b1, PWR.clkgen_off);
    chkb("osc", 1'b0, PWR.osc_run);
    chkb("regsb", 1'b1, PWR.reg_standby);
    chkb("conv_sb", 1'b1, PWR.conv_standby);
    chkb("kp_off", 1'b1, PWR.keypad_off);
    chkb("periph", 1'b0, PWR.periph_clk_en);
    WAKE_SRC <= 7'h01;
    wait_mode(3'h3);
    chkb("sysrst", 1'b1, SYS_RESET_REQ);
    WAKE_SRC <= 7'h00;
    wait_mode(3'h0);
    apb(1'b0, OFS_STAT, 32'h0);
    chkw("stat", 32'h18, rd);
    apb(1'b0, OFS_CTRL, 32'h0);
    chkw("ctrl", 32'h0, rd);
    apb(1'b1, OFS_ACK, 32'h1);
    apb(1'b0, OFS_STAT, 32'h0);
    chkw("stat", 32'h0, rd);
  endtask

  task automatic t_dbg();
    apb(1'b1, OFS_CTRL, 32'h43);
    stop();
    chkw("mode", 32'h1, 32'(MODE));
    chkb("dbgclk", 1'b1, PWR.dbg_clk_en);
    chkb("regsb", 1'b0, PWR.reg_standby);
    chkb("periph", 1'b0, PWR.periph_clk_en);
    dbg(DBG_MEM_STAT);
    chkb("err", 1'b1, DBG_RSP.err_stopped);
    dbg(DBG_BGND);
    chkb("ack", 1'b1, DBG_RSP.ack);
    chkw("mode", 32'h4, 32'(MODE));
    dbg(DBG_CPU_REG);
    chkb("ack", 1'b1, DBG_RSP.ack);
    dbg(DBG_GO);
    chkw("mode", 32'h0, 32'(MODE));
  endtask

  task automatic t_lowv();
    apb(1'b1, OFS_CTRL, 32'h2f);
    stop();
    chkw("mode", 32'h1, 32'(MODE));
    chkb("regsb", 1'b0, PWR.reg_standby);
    chkb("cg_sb", 1'b1, PWR.clkgen_standby);
    chkb("osc", 1'b0, PWR.osc_run);
    chkb("kpwake", 1'b1, PWR.keypad_wake_en);
    chkb("conv_sb", 1'b0, PWR.conv_standby);
    chkb("conv_run", 1'b1, PWR.conv_run_stop);
    chkb("latch", 1'b0, PWR.pin_latch);
    chkb("sysrst", 1'b0, SYS_RESET_REQ);
    WAKE_SRC <= 7'h10;
    wait_mode(3'h0);
    chkw("mode", 32'h0, 32'(MODE));
    WAKE_SRC <= 7'h00;
  endtask

  initial
  begin
    RESET_N = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    STOP_EXEC = 1'b0;
    WAKE_SRC = 7'h00;
    repeat (5) @(posedge CLK);
    RESET_N <= 1'b1;
    t_run();
    t_deep();
    t_dbg();
    t_lowv();
    end_of_test();
  end
endmodule
`default_nettype wire
